// ==== bsd_pkg.sv ====
// Function
// - Skew is biased offset A minus biased offset B, swapped when side select high.
// - Drift is 12000 minus half the sum of both biased offsets.
// - Computed skew drives the signed skew output continuously.
// - Computed drift drives the signed drift output continuously.
// - Drift loop sets skew setpoint; skew loop corrects speed reference difference.
// - Sway combination input selects mode and may change at run time.
// - Standalone mode forwards requested ramp times so drives do the ramping.
// - Sway combination mode forces both ramp outputs to the shortest ramp time.
// - Enable low passes speed, ramps and directions unchanged to both drives.
// - Standalone mode rewrites speeds and ramps for both drives every cycle.
// - Alarm clears on rising clear edge only once its cause has gone.
package bsd_pkg;

  // ----------------------------------------------------------------
  // Widths and constants
  // ----------------------------------------------------------------
  localparam int unsigned         WORD_W      = 16;
  localparam int unsigned         CALC_W      = 20;
  localparam int unsigned         GAIN_W      = 16;
  localparam int unsigned         GAIN_FRAC   = 8;
  localparam logic signed [19:0]  SENSOR_BIAS = 20'sd12000;
  localparam logic [15:0]         RAMP_MIN    = 16'h0000;
  localparam logic signed [15:0]  OUT_MAX     = 16'sh7FFF;
  localparam logic signed [15:0]  OUT_MIN     = -16'sh8000;
  localparam logic [15:0]         SPD_ZERO    = 16'h0000;

  // Command to one drive
  typedef struct packed {
    logic [15:0] speed;
    logic [15:0] acc;
    logic [15:0] dec;
  } bsd_drive_cmd_t;

  // Sensor readings and commissioned centers
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] a_center;
    logic [15:0] b_center;
  } bsd_sensor_t;

  // Mode states
  typedef enum logic [2:0] {
    BSD_FALLBACK   = 3'b001,
    BSD_STANDALONE = 3'b010,
    BSD_SWAY       = 3'b100
  } bsd_mode_t;

endpackage

// ==== bsd_geometry.sv ====
`timescale 1ns/10ps
`default_nettype none
module bsd_geometry
  import bsd_pkg::*;
(
  input  wire logic               ref_clk_in,
  input  wire logic               rst_n_in,
  input  wire bsd_sensor_t        sensor_in,
  input  wire logic               sensor_side_select_in,
  output logic signed [15:0]      skew_out,
  output logic signed [15:0]      drift_out
);

  // ----------------------------------------------------------------
  // Arithmetic helpers
  // ----------------------------------------------------------------
  // Biased offset, 20 bits covers 0..65535 spans without wrap
  function automatic logic signed [19:0] biased(input logic [15:0] rd,
                                                input logic [15:0] ctr);
    biased = $signed({4'h0, rd}) - $signed({4'h0, ctr}) + SENSOR_BIAS;
  endfunction

  function automatic logic signed [15:0] sat16(input logic signed [19:0] v);
    if (v > 20'(OUT_MAX))
      sat16 = OUT_MAX;
    else if (v < 20'(OUT_MIN))
      sat16 = OUT_MIN;
    else
      sat16 = v[15:0];
  endfunction

  typedef struct packed {
    logic signed [15:0] skew;
    logic signed [15:0] drift;
  } bsd_geo_state_t;

  bsd_geo_state_t st_reg;
  bsd_geo_state_t st_next;
  logic signed [19:0] off_a;
  logic signed [19:0] off_b;
  logic signed [20:0] sum_ab;
  logic signed [20:0] drift_w;

  // ----------------------------------------------------------------
  // Skew and drift
  // ----------------------------------------------------------------
  always_comb begin
    off_a   = biased(sensor_in.a, sensor_in.a_center);
    off_b   = biased(sensor_in.b, sensor_in.b_center);
    sum_ab  = 21'(off_a) + 21'(off_b);
    drift_w = 21'(SENSOR_BIAS) - (sum_ab >>> 1);
    st_next = st_reg;
    if (!sensor_side_select_in)
      st_next.skew = sat16(off_a - off_b);
    else
      st_next.skew = sat16(off_b - off_a);
    // Sum of two 20-bit offsets halved fits 20 bits
    st_next.drift = sat16(drift_w[19:0]);
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign skew_out  = st_reg.skew;
  assign drift_out = st_reg.drift;

  // Flipping side select with steady sensors negates skew; skip saturated ends
  AST_SKEW_SIGN: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $past(rst_n_in) && $stable(sensor_in) && $changed(sensor_side_select_in)
    && skew_out != OUT_MAX && skew_out != OUT_MIN |=> skew_out == -$past(skew_out))
    else $error("skew did not flip with side select");
  AST_DRIFT_CENTER: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    sensor_in.a == sensor_in.a_center && sensor_in.b == sensor_in.b_center
    |=> drift_out == 16'sh0000)
    else $error("drift wrong at centered sensors");

endmodule
`default_nettype wire

// ==== bsd_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module bsd_top
  import bsd_pkg::*;
(
  input  wire logic               ref_clk_in,
  input  wire logic               rst_n_in,
  input  wire logic               block_enable_in,
  input  wire logic               sway_combo_select_in,
  input  wire logic               sensor_side_select_in,
  input  wire logic               drive_fwd_in,
  input  wire logic               drive_rev_in,
  input  wire logic [15:0]        speed_ref_in,
  input  wire logic [15:0]        accel_time_in,
  input  wire logic [15:0]        decel_time_in,
  input  wire bsd_sensor_t        sensor_in,
  input  wire logic [15:0]        drift_gain_in,
  input  wire logic [15:0]        skew_gain_in,
  input  wire logic [15:0]        correction_max_in,
  input  wire logic [15:0]        skew_max_in,
  input  wire logic [15:0]        drift_max_in,
  input  wire logic               alarm_clear_in,
  output logic                    enable_out,
  output logic                    drive_fwd_out,
  output logic                    drive_rev_out,
  output bsd_drive_cmd_t          drive1_cmd_out,
  output bsd_drive_cmd_t          drive2_cmd_out,
  output logic signed [15:0]      skew_actual_out,
  output logic signed [15:0]      drift_actual_out,
  output logic                    alarm_flag_out,
  output bsd_mode_t               mode_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    bsd_mode_t      mode;
    bsd_drive_cmd_t d1;
    bsd_drive_cmd_t d2;
    logic           fwd;
    logic           rev;
    logic           en;
    logic           alarm;
    logic           clr_prev;
  } bsd_top_state_t;

  bsd_top_state_t     st_reg;
  bsd_top_state_t     st_next;
  logic signed [15:0] skew_w;
  logic signed [15:0] drift_w;
  logic signed [35:0] skew_sp;
  logic signed [35:0] skew_err;
  logic signed [35:0] corr_raw;
  logic signed [17:0] corr;
  logic signed [17:0] half;
  logic signed [18:0] sp1;
  logic signed [18:0] sp2;
  logic               cause;

  // Fixed-point gain product, gain is unsigned Q8.8
  function automatic logic signed [35:0] gain_mul(input logic signed [35:0] v,
                                                  input logic [15:0] g);
    logic signed [52:0] p;
    p = 53'(v) * $signed({37'h0, g});
    gain_mul = p[43:8];
  endfunction

  // Clamp a wide speed to the unsigned drive range
  function automatic logic [15:0] clamp_spd(input logic signed [18:0] v);
    if (v < 19'sd0)
      clamp_spd = SPD_ZERO;
    else if (v > 19'sd65535)
      clamp_spd = 16'hFFFF;
    else
      clamp_spd = v[15:0];
  endfunction

  // ----------------------------------------------------------------
  // Skew and drift measurement
  // ----------------------------------------------------------------
  bsd_geometry u_geo (
    .ref_clk_in            (ref_clk_in),
    .rst_n_in              (rst_n_in),
    .sensor_in             (sensor_in),
    .sensor_side_select_in (sensor_side_select_in),
    .skew_out              (skew_w),
    .drift_out             (drift_w)
  );

  // ----------------------------------------------------------------
  // Correction cascade and mode handling
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // Outer drift loop yields the skew setpoint
    skew_sp  = gain_mul(36'(drift_w), drift_gain_in);
    skew_err = skew_sp - 36'(skew_w);
    corr_raw = gain_mul(skew_err, skew_gain_in);
    // Limit speed difference so one bogie never reverses the other
    if (corr_raw > $signed({20'h0, correction_max_in}))
      corr = $signed({2'b00, correction_max_in});
    else if (corr_raw < -$signed({20'h0, correction_max_in}))
      corr = -$signed({2'b00, correction_max_in});
    else
      corr = corr_raw[17:0];
    half = corr >>> 1;
    sp1  = $signed({3'b000, speed_ref_in}) + 19'(half);
    sp2  = $signed({3'b000, speed_ref_in}) - 19'(corr - half);
    // Mode decided every cycle so it may switch live
    if (!block_enable_in)
      st_next.mode = BSD_FALLBACK;
    else if (sway_combo_select_in)
      st_next.mode = BSD_SWAY;
    else
      st_next.mode = BSD_STANDALONE;
    st_next.en  = block_enable_in;
    st_next.fwd = drive_fwd_in;
    st_next.rev = drive_rev_in;
    unique case (st_next.mode)
      BSD_FALLBACK: begin
        // Pass straight through, no correction
        st_next.d1 = '{speed_ref_in, accel_time_in, decel_time_in};
        st_next.d2 = '{speed_ref_in, accel_time_in, decel_time_in};
      end
      BSD_STANDALONE: begin
        // Rewritten every cycle; drives ramp themselves
        st_next.d1 = '{clamp_spd(sp1), accel_time_in, decel_time_in};
        st_next.d2 = '{clamp_spd(sp2), accel_time_in, decel_time_in};
      end
      BSD_SWAY: begin
        st_next.d1 = '{clamp_spd(sp1), RAMP_MIN, RAMP_MIN};
        st_next.d2 = '{clamp_spd(sp2), RAMP_MIN, RAMP_MIN};
      end
    endcase
    // Alarm latches on limit breach while enabled, clears only once cause is gone
    cause = (skew_w > $signed({1'b0, skew_max_in}) ||
             -skew_w > $signed({1'b0, skew_max_in}) ||
             drift_w > $signed({1'b0, drift_max_in}) ||
             -drift_w > $signed({1'b0, drift_max_in})) && block_enable_in;
    st_next.clr_prev = alarm_clear_in;
    if (cause)
      st_next.alarm = 1'b1;
    else if (alarm_clear_in && !st_reg.clr_prev)
      st_next.alarm = 1'b0;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in)
      st_reg <= '{mode: BSD_FALLBACK, default: '0};
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign skew_actual_out  = skew_w;
  assign drift_actual_out = drift_w;
  assign drive1_cmd_out   = st_reg.d1;
  assign drive2_cmd_out   = st_reg.d2;
  assign drive_fwd_out    = st_reg.fwd;
  assign drive_rev_out    = st_reg.rev;
  assign enable_out       = st_reg.en;
  assign alarm_flag_out   = st_reg.alarm;
  assign mode_out         = st_reg.mode;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_SWAY_RAMPS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    block_enable_in && sway_combo_select_in |=> drive1_cmd_out.acc == RAMP_MIN
    && drive2_cmd_out.dec == RAMP_MIN && drive1_cmd_out.dec == RAMP_MIN)
    else $error("sway ramps not minimal");
  AST_STANDALONE_RAMPS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    block_enable_in && !sway_combo_select_in |=> drive1_cmd_out.acc == $past(accel_time_in)
    && drive2_cmd_out.dec == $past(decel_time_in))
    else $error("standalone ramps not forwarded");
  AST_FALLBACK_PASS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !block_enable_in |=> drive1_cmd_out.speed == $past(speed_ref_in)
    && drive2_cmd_out.speed == $past(speed_ref_in) && drive_fwd_out == $past(drive_fwd_in))
    else $error("fallback did not pass through");
  AST_MODE_SWITCH: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    block_enable_in ##1 block_enable_in && $changed(sway_combo_select_in)
    |=> $changed(mode_out))
    else $error("mode did not follow sway select");
  // Equal offsets on both sensors must read as zero skew on the pin
  AST_SKEW_OUT: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    17'(sensor_in.a) - 17'(sensor_in.a_center) == 17'(sensor_in.b) - 17'(sensor_in.b_center)
    |=> skew_actual_out == 16'sh0000)
    else $error("skew output not zero for matched offsets");
  // Drift ignores the mounting side, so a side flip leaves it alone
  AST_DRIFT_OUT: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $past(rst_n_in) && $stable(sensor_in) && $changed(sensor_side_select_in)
    |=> $stable(drift_actual_out))
    else $error("drift output moved with side select");
  AST_ALARM_HOLD: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    alarm_flag_out && !(alarm_clear_in && !st_reg.clr_prev) |=> alarm_flag_out)
    else $error("alarm dropped without clear edge");
  AST_CORR_SPLIT: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    block_enable_in && corr == 18'sd0 && speed_ref_in < 16'hFF00
    |=> drive1_cmd_out.speed == drive2_cmd_out.speed)
    else $error("speeds differ with no correction");
  AST_EVERY_CYCLE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    block_enable_in && !sway_combo_select_in && $changed(accel_time_in)
    |=> $changed(drive2_cmd_out.acc))
    else $error("ramp not rewritten");
  // Clamping to the drive range can only shrink the speed gap
  AST_CORR_LIMIT: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    1'b1 |=> (17'(drive1_cmd_out.speed) - 17'(drive2_cmd_out.speed)
              <= 17'($past(correction_max_in)))
      || (17'(drive2_cmd_out.speed) - 17'(drive1_cmd_out.speed)
              <= 17'($past(correction_max_in))))
    else $error("speed difference above correction limit");
  AST_ALARM_SET: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    cause |=> alarm_flag_out)
    else $error("alarm not raised on cause");
  AST_ALARM_CLEAR: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    alarm_flag_out && !cause && alarm_clear_in && !st_reg.clr_prev |=> !alarm_flag_out)
    else $error("alarm not cleared on clear edge");
  AST_DIR_PASS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    1'b1 |=> drive_rev_out == $past(drive_rev_in) && enable_out == $past(block_enable_in))
    else $error("direction or enable not passed through");

endmodule
`default_nettype wire

// ==== bsd_drive_pair_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module bsd_drive_pair_model
  import bsd_pkg::*;
(
  input  wire logic            ref_clk_in,
  input  wire logic            rst_n_in,
  input  wire bsd_drive_cmd_t  drive1_cmd_in,
  input  wire bsd_drive_cmd_t  drive2_cmd_in,
  output logic signed [16:0]   speed_diff_out
);
  // ----------------------------------------------------------------
  // Two drives taking a fresh target every cycle
  // ----------------------------------------------------------------
  // Each drive latches its word anew; a missed write shows as a stale gap
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      speed_diff_out <= '0;
    end else begin
      speed_diff_out <= $signed({1'b0, drive1_cmd_in.speed}) -
                        $signed({1'b0, drive2_cmd_in.speed});
    end
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import bsd_pkg::*;
  logic ref_clk_in, rst_n_in, en, sway, side, fwd, rev, clr;
  logic [15:0] spd, acc, dec, kd, ks, cmax, smax, dmax;
  bsd_sensor_t sens;
  logic en_o, fwd_o, rev_o, alarm_o;
  bsd_drive_cmd_t d1, d2;
  logic signed [15:0] skew_o, drift_o;
  logic signed [16:0] diff_o;
  bsd_mode_t mode_o;
  int fails, checks_done, seed;
  logic [15:0] gains [3] = '{16'h0000, 16'h0100, 16'h0200};

  bsd_top uut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .block_enable_in(en),
    .sway_combo_select_in(sway), .sensor_side_select_in(side), .drive_fwd_in(fwd),
    .drive_rev_in(rev), .speed_ref_in(spd), .accel_time_in(acc), .decel_time_in(dec),
    .sensor_in(sens), .drift_gain_in(kd), .skew_gain_in(ks), .correction_max_in(cmax),
    .skew_max_in(smax), .drift_max_in(dmax), .alarm_clear_in(clr), .enable_out(en_o),
    .drive_fwd_out(fwd_o), .drive_rev_out(rev_o), .drive1_cmd_out(d1),
    .drive2_cmd_out(d2), .skew_actual_out(skew_o), .drift_actual_out(drift_o),
    .alarm_flag_out(alarm_o), .mode_out(mode_o));
  bsd_drive_pair_model drives (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .drive1_cmd_in(d1), .drive2_cmd_in(d2), .speed_diff_out(diff_o));

  // ----------------------------------------------------------------
  // Clock, compare and closing tasks
  // ----------------------------------------------------------------
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %0d seen %0d", nm, $signed(e), $signed(g));
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic int clip(input int v, input int lo, input int hi);
    return (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction

  // ----------------------------------------------------------------
  // Reference model; inputs held steady long enough to settle
  // ----------------------------------------------------------------
  task automatic check_all();
    int oa, ob, sk, dr, cr, s1, s2;
    bsd_mode_t m;
    oa = int'(sens.a) - int'(sens.a_center) + 12000;
    ob = int'(sens.b) - int'(sens.b_center) + 12000;
    sk = clip(side ? ob - oa : oa - ob, -32768, 32767);
    dr = clip(12000 - ((oa + ob) >>> 1), -32768, 32767);
    cr = clip(((((dr * int'(kd)) >>> 8) - sk) * int'(ks)) >>> 8, -int'(cmax), int'(cmax));
    m = !en ? BSD_FALLBACK : sway ? BSD_SWAY : BSD_STANDALONE;
    if (!en) cr = 0;
    s1 = clip(int'(spd) + (cr >>> 1), 0, 65535);
    s2 = clip(int'(spd) - (cr - (cr >>> 1)), 0, 65535);
    chk_w("skew", sk, skew_o);
    chk_w("drift", dr, drift_o);
    chk_w("mode", m, mode_o);
    chk_w("speed1", s1, d1.speed);
    chk_w("speed2", s2, d2.speed);
    chk_w("diff", s1 - s2, diff_o);
    chk_w("acc1", (m == BSD_SWAY) ? RAMP_MIN : acc, d1.acc);
    chk_w("dec2", (m == BSD_SWAY) ? RAMP_MIN : dec, d2.dec);
    chk_w("acc2", (m == BSD_SWAY) ? RAMP_MIN : acc, d2.acc);
    chk_w("dec1", (m == BSD_SWAY) ? RAMP_MIN : dec, d1.dec);
    chk_w("dirs", {en, fwd, rev}, {en_o, fwd_o, rev_o});
  endtask

  // Hang guard, sized well past the expected run
  initial begin
    #200000;
    fails++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    fails = 0;
    checks_done = 0;
    seed = 32'hc1ac;
    rst_n_in = 1'b0;
    {en, sway, side, fwd, rev, clr} = '0;
    {spd, acc, dec, kd, ks, cmax} = '0;
    {smax, dmax} = {16'hFFFF, 16'hFFFF};
    sens = '{16'd12000, 16'd12000, 16'd12000, 16'd12000};
    repeat (4) @(posedge ref_clk_in);
    #1;
    chk_w("reset_mode", BSD_FALLBACK, mode_o);
    chk_w("reset_speed", 0, d1.speed);
    rst_n_in = 1'b1;
    // Random sweep; first pass drives the sensors past their range to saturate
    // Every fourth pass keeps the sensors so only side select can move
    for (int i = 0; i < 300; i++) begin
      en = 1'($random(seed));
      sway = 1'($random(seed));
      side = 1'($random(seed));
      {fwd, rev} = 2'($random(seed));
      {spd, acc, dec} = {16'($random(seed)), 16'($random(seed)), 16'($random(seed))};
      kd = gains[$unsigned($random(seed)) % 3];
      ks = gains[$unsigned($random(seed)) % 3];
      cmax = (i % 7 == 0) ? 16'h0000 : 16'($random(seed));
      if (i == 0) sens = '{16'hFFFF, 16'h0000, 16'h0000, 16'hFFFF};
      else if (i % 4 != 3) sens = '{16'(4000 + $unsigned($random(seed)) % 16001),
                    16'(4000 + $unsigned($random(seed)) % 16001),
                    16'(4000 + $unsigned($random(seed)) % 16001),
                    16'(4000 + $unsigned($random(seed)) % 16001)};
      step(3);
      check_all();
      chk_w("alarm_idle", 0, alarm_o);
    end
    // Alarm: latch, refuse clear while cause stands, clear after it goes
    en = 1'b1;
    smax = 16'd100;
    sens = '{16'd13000, 16'd12000, 16'd12000, 16'd12000};
    step(3);
    chk_w("alarm_set", 1, alarm_o);
    clr = 1'b1;
    step(3);
    chk_w("alarm_held", 1, alarm_o);
    clr = 1'b0;
    sens = '{16'd12000, 16'd12000, 16'd12000, 16'd12000};
    step(3);
    chk_w("alarm_latched", 1, alarm_o);
    clr = 1'b1;
    step(3);
    chk_w("alarm_cleared", 0, alarm_o);
    check_all();
    wrap_up();
  end
endmodule
`default_nettype wire
